// ===== ntac_defines.svh
`ifndef NTAC_DEFINES_SVH
`define NTAC_DEFINES_SVH
`define NTAC_CMD_WRITE_REG   8'h09
`define NTAC_CMD_ANTICOLLISION_FILTER   8'h0d
`define NTAC_IDX_AUTO_SYNC   8'h0a
`define NTAC_IDX_TIMER_WIN   8'h3a
`define NTAC_TW_MIN          8'h50
`define NTAC_TW_MAX          8'h60
`define NTAC_TW_RESET        8'h52
`define NTAC_TW_CONFIRM      8'h04
`define NTAC_AS_ENABLE       8'h02
`define NTAC_AS_CONFIRM      8'ha1
`define NTAC_WR_LEN_SHORT    8'h03
`define NTAC_WR_LEN_LONG     8'h04
`define NTAC_INC_ON          8'h01
`define NTAC_ACF_LEN_OFF     8'h00
`define NTAC_ACF_LEN_SET     8'h01
`define NTAC_ACF_LEN_GET     8'h02
`define NTAC_ACF_LEN_CL1     8'h07
`define NTAC_ACF_LEN_CL2     8'h0b
`define NTAC_ACF_LEN_CL3     8'h0f
`define NTAC_RES_OK          8'h00
`define NTAC_ERR_LEN         8'h82
`define NTAC_ST_IDLE         8'h00
`define NTAC_ST_READY        8'h01
`define NTAC_ST_ACTIVE       8'h04
`define NTAC_ST_HALT         8'h80
`define NTAC_ST_READY_HALT   8'h81
`define NTAC_ST_ACTIVE_HALT  8'h84
`endif

// ===== ntac_pkg.sv
package ntac_pkg;
   typedef enum logic [3:0] {
      NTAC_P_CMD  = 4'b0001,
      NTAC_P_LEN  = 4'b0010,
      NTAC_P_PAY  = 4'b0100,
      NTAC_P_SKIP = 4'b1000
   } ntac_phase_t;

   typedef struct packed {
      logic [15:0] atqa;
      logic [7:0]  sak;
      logic [95:0] uid;
      logic [1:0]  levels;
   } ntac_acf_cfg_t;

   typedef struct packed {
      logic [7:0] data;
      logic       valid;
   } ntac_byte_t;

   typedef struct packed {
      logic [2:0] sck;
      logic [1:0] mosi;
      logic [2:0] ssN;
      logic [2:0] bitCnt;
      logic [7:0] rxSh;
      logic [7:0] txSh;
      ntac_byte_t rx;
      logic       txTaken;
   } ntac_link_st_t;

   typedef struct packed {
      ntac_phase_t    phase;
      logic [7:0]     cmd;
      logic [7:0]     len;
      logic [3:0]     cnt;
      logic [14:0][7:0] pay;
      logic [7:0]     twin;
      logic           asEn;
      logic           acfOn;
      logic [7:0]     emu;
      ntac_acf_cfg_t  cfg;
      logic [7:0]     regPtr;
      logic [2:0][7:0] rep;
      logic [1:0]     repCnt;
   } ntac_cmd_st_t;
endpackage : ntac_pkg

// ===== ntac_spi_link.sv
`timescale 1ns/100ps
module ntac_spi_link
   import ntac_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       spiSck,
   input  wire logic       spiMosi,
   input  wire logic       spiSsN,
   input  wire logic [7:0] txByte,
   output ntac_byte_t      rxByte,
   output logic            txTaken,
   output logic            linkSel,
   output logic            spiMiso,
   output logic            spiMisoOe
);
   ntac_link_st_t q, n;
   logic rise, fall, csFall, active;

   always_comb begin
      n         = q;
      n.sck     = {q.sck[1:0], spiSck};
      n.mosi    = {q.mosi[0], spiMosi};
      n.ssN     = {q.ssN[1:0], spiSsN};
      n.rx.valid = 1'b0;
      n.txTaken = 1'b0;
      // edges found on stages two and three only
      rise      = q.sck[1] & ~q.sck[2];
      fall      = ~q.sck[1] & q.sck[2];
      active    = ~q.ssN[1];
      csFall    = ~q.ssN[1] & q.ssN[2];
      if (!active) begin
         n.bitCnt = 3'd0;
      end else if (csFall) begin
         n.txSh    = txByte;
         n.txTaken = 1'b1;
         n.bitCnt  = 3'd0;
      end else if (rise) begin
         n.rxSh   = {q.rxSh[6:0], q.mosi[1]};
         n.bitCnt = q.bitCnt + 3'd1;
         if (q.bitCnt == 3'd7) begin
            n.rx.data  = {q.rxSh[6:0], q.mosi[1]};
            n.rx.valid = 1'b1;
            // next byte loaded on the last rising edge, so no falling shift follows
            n.txSh     = txByte;
            n.txTaken  = 1'b1;
         end
      end else if (fall && q.bitCnt != 3'd0) begin
         n.txSh = {q.txSh[6:0], 1'b0};
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         q <= '{sck: 3'b000, mosi: 2'b00, ssN: 3'b111, bitCnt: 3'd0, rxSh: 8'h00,
                txSh: 8'h00, rx: '{data: 8'h00, valid: 1'b0}, txTaken: 1'b0};
      end else begin
         q <= n;
      end
   end

   assign rxByte    = q.rx;
   assign txTaken   = q.txTaken;
   assign linkSel   = ~q.ssN[1];
   assign spiMiso   = q.txSh[7];
   assign spiMisoOe = ~q.ssN[1];
endmodule : ntac_spi_link

// ===== ntac_cmd.sv
`timescale 1ns/100ps
`include "ntac_defines.svh"
module ntac_cmd
   import ntac_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       spiSck,
   input  wire logic       spiMosi,
   input  wire logic       spiSsN,
   output logic            spiMiso,
   output logic            spiMisoOe,
   input  wire logic       protoSelPulse,
   input  wire logic       acStateLoad,
   input  wire logic [7:0] acStateIn,
   output logic [7:0]      demodTimerWindow,
   output logic            autoSyncFilterEn,
   output logic            acFilterActive,
   output logic [7:0]      emuState,
   output ntac_acf_cfg_t   acfConfig,
   output logic [7:0]      regAddrPtr,
   output logic            bufferAllFrames
);
   ntac_cmd_st_t q, n;
   ntac_byte_t   rxByte;
   logic         txTaken;
   logic         linkSel;
   logic         lastByte;
   logic         execAcf;
   logic         lenBad;
   logic [7:0]   idx;
   logic [7:0]   val;
   logic         confOk;

   ntac_spi_link u_link (
      .clock     (clock),
      .rst       (rst),
      .spiSck    (spiSck),
      .spiMosi   (spiMosi),
      .spiSsN    (spiSsN),
      .txByte    (q.rep[0]),
      .rxByte    (rxByte),
      .txTaken   (txTaken),
      .linkSel   (linkSel),
      .spiMiso   (spiMiso),
      .spiMisoOe (spiMisoOe)
   );

   assign lastByte = rxByte.valid && q.phase == NTAC_P_PAY && ({4'd0, q.cnt} + 8'd1) == q.len;
   assign execAcf  = lastByte && q.cmd == `NTAC_CMD_ANTICOLLISION_FILTER;
   assign lenBad   = rxByte.data > `NTAC_ACF_LEN_GET && rxByte.data != `NTAC_ACF_LEN_CL1
                     && rxByte.data != `NTAC_ACF_LEN_CL2 && rxByte.data != `NTAC_ACF_LEN_CL3;

   always_comb begin
      n      = q;
      idx    = 8'h00;
      val    = 8'h00;
      confOk = 1'b0;
      // reply drains one byte per byte slot; empty slots send 0x00
      if (txTaken && q.repCnt != 2'd0) begin
         n.rep    = {8'h00, q.rep[2], q.rep[1]};
         n.repCnt = q.repCnt - 2'd1;
      end
      if (acStateLoad) begin
         n.emu = acStateIn;
      end
      if (!linkSel) begin
         n.phase = NTAC_P_CMD;
      end else if (rxByte.valid) begin
         case (q.phase)
            NTAC_P_CMD: begin
               if (rxByte.data == `NTAC_CMD_WRITE_REG || rxByte.data == `NTAC_CMD_ANTICOLLISION_FILTER) begin
                  n.cmd   = rxByte.data;
                  n.phase = NTAC_P_LEN;
               end else begin
                  n.phase = NTAC_P_SKIP;
               end
            end
            NTAC_P_LEN: begin
               n.len   = rxByte.data;
               n.cnt   = 4'd0;
               n.phase = NTAC_P_PAY;
               if (q.cmd == `NTAC_CMD_ANTICOLLISION_FILTER && rxByte.data == `NTAC_ACF_LEN_OFF) begin
                  n.acfOn  = 1'b0;
                  n.rep    = {q.emu, 8'h01, `NTAC_RES_OK};
                  n.repCnt = 2'd3;
                  n.phase  = NTAC_P_SKIP;
               end else if (q.cmd == `NTAC_CMD_ANTICOLLISION_FILTER && lenBad) begin
                  n.rep    = {8'h00, 8'h00, `NTAC_ERR_LEN};
                  n.repCnt = 2'd2;
                  n.phase  = NTAC_P_SKIP;
               end else if (q.cmd == `NTAC_CMD_WRITE_REG && rxByte.data != `NTAC_WR_LEN_SHORT
                            && rxByte.data != `NTAC_WR_LEN_LONG) begin
                  // only lengths 3 and 4 accepted
                  n.rep    = {8'h00, 8'h00, `NTAC_ERR_LEN};
                  n.repCnt = 2'd2;
                  n.phase  = NTAC_P_SKIP;
               end
            end
            NTAC_P_PAY: begin
               n.pay[q.cnt] = rxByte.data;
               n.cnt        = q.cnt + 4'd1;
            end
            NTAC_P_SKIP: begin
               n.phase = NTAC_P_SKIP;
            end
            default: begin
               n.phase = NTAC_P_SKIP;
            end
         endcase
         if (lastByte) begin
            n.phase  = NTAC_P_SKIP;
            n.rep    = {8'h00, 8'h00, `NTAC_RES_OK};
            n.repCnt = 2'd2;
            if (q.cmd == `NTAC_CMD_WRITE_REG) begin
               idx    = n.pay[0];
               val    = n.pay[2];
               // short form carries no confirmation byte
               if (idx == `NTAC_IDX_TIMER_WIN) begin
                  confOk = q.len == `NTAC_WR_LEN_SHORT || n.pay[3] == `NTAC_TW_CONFIRM;
                  if (confOk && val >= `NTAC_TW_MIN && val <= `NTAC_TW_MAX) begin
                     n.twin = val;
                  end
               end else if (idx == `NTAC_IDX_AUTO_SYNC) begin
                  confOk = q.len == `NTAC_WR_LEN_SHORT || n.pay[3] == `NTAC_AS_CONFIRM;
                  if (confOk) begin
                     n.asEn = val == `NTAC_AS_ENABLE;
                  end
               end
               n.regPtr = (n.pay[1] == `NTAC_INC_ON) ? idx + 8'h01 : idx;
            end else if (q.len == `NTAC_ACF_LEN_SET) begin
               n.emu = n.pay[0];
            end else if (q.len == `NTAC_ACF_LEN_GET) begin
               if (n.pay[0] == 8'h00 && n.pay[1] == 8'h00) begin
                  n.rep    = {q.emu, 8'h01, `NTAC_RES_OK};
                  n.repCnt = 2'd3;
               end else begin
                  n.rep = {8'h00, 8'h00, `NTAC_ERR_LEN};
               end
            end else begin
               // ATQA, SAK and UID parts latched
               n.cfg.atqa = {n.pay[0], n.pay[1]};
               n.cfg.sak  = n.pay[2];
               for (int i = 0; i < 12; i++) begin
                  n.cfg.uid[95 - 8 * i -: 8] = n.pay[3 + i];
               end
               n.cfg.levels = (q.len == `NTAC_ACF_LEN_CL1) ? 2'd1 :
                              (q.len == `NTAC_ACF_LEN_CL2) ? 2'd2 : 2'd3;
               n.acfOn = 1'b1;
            end
         end
      end
      // protocol select restores tuning defaults, wins over writes
      if (protoSelPulse) begin
         n.twin = `NTAC_TW_RESET;
         n.asEn = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         q        <= '0;
         q.phase  <= NTAC_P_CMD;
         q.twin   <= `NTAC_TW_RESET;
         q.emu    <= `NTAC_ST_IDLE;
      end else begin
         q <= n;
      end
   end

   assign demodTimerWindow = q.twin;
   assign autoSyncFilterEn = q.asEn;
   assign acFilterActive   = q.acfOn;
   assign emuState         = q.emu;
   assign acfConfig        = q.cfg;
   assign regAddrPtr       = q.regPtr;
   // buffer every frame only while the filter is off
   assign bufferAllFrames  = ~q.acfOn;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_tw_range: assert property (q.twin >= `NTAC_TW_MIN && q.twin <= `NTAC_TW_MAX)
      else $error("timer window out of range");
   a_tw_default: assert property (protoSelPulse |=> demodTimerWindow == `NTAC_TW_RESET)
      else $error("timer window not restored");
   a_as_off: assert property (protoSelPulse |=> !autoSyncFilterEn)
      else $error("auto sync filter still on");
   a_err_reply: assert property (rxByte.valid && linkSel && q.phase == NTAC_P_LEN
         && q.cmd == `NTAC_CMD_ANTICOLLISION_FILTER && lenBad
         |=> q.repCnt == 2'd2 && q.rep[0] == `NTAC_ERR_LEN && q.rep[1] == 8'h00)
      else $error("bad length not rejected");
   a_deact_reply: assert property (rxByte.valid && linkSel && q.phase == NTAC_P_LEN
         && q.cmd == `NTAC_CMD_ANTICOLLISION_FILTER && rxByte.data == 8'h00
         |=> !acFilterActive && q.repCnt == 2'd3 && q.rep[1] == 8'h01 && q.rep[2] == $past(q.emu))
      else $error("deactivate reply wrong");
   a_set_state: assert property (linkSel && execAcf && q.len == `NTAC_ACF_LEN_SET
         |=> emuState == $past(rxByte.data) && q.repCnt == 2'd2 && q.rep[0] == 8'h00)
      else $error("state not forced");
   a_get_state: assert property (linkSel && execAcf && q.len == `NTAC_ACF_LEN_GET
         && rxByte.data == 8'h00 && q.pay[0] == 8'h00
         |=> acFilterActive == $past(q.acfOn) && q.rep[1] == 8'h01 && q.rep[2] == $past(q.emu))
      else $error("state report wrong");
   a_activate: assert property (linkSel && execAcf && q.len > `NTAC_ACF_LEN_GET
         |=> acFilterActive && q.repCnt == 2'd2 && q.rep[0] == 8'h00 ##1 acFilterActive || !linkSel)
      else $error("filter not activated");

   c_activate: cover property (linkSel && execAcf && q.len == `NTAC_ACF_LEN_CL2);
   c_tw_write: cover property (lastByte && q.cmd == `NTAC_CMD_WRITE_REG ##1 q.twin != `NTAC_TW_RESET);
   c_deact: cover property (q.acfOn ##1 !q.acfOn);
endmodule : ntac_cmd

// ===== ntac_host_model.sv
`timescale 1ns/100ps
module ntac_host_model (
   output logic      spiSck,
   output logic      spiMosi,
   output logic      spiSsN,
   input  wire logic spiMiso
);
   localparam int HALF = 160;
   logic [7:0] rxq [$];

   initial begin
      spiSck  = 1'b0;
      spiMosi = 1'b1;
      spiSsN  = 1'b1;
   end

   // one select-low period, mode 0, msb first; reply bytes collect in rxq
   task automatic frame(input logic [7:0] txq [$]);
      logic [7:0] r;
      rxq = {};
      // offset keeps link edges away from system clock edges
      #7;
      spiSsN = 1'b0;
      foreach (txq[i]) begin
         for (int b = 7; b >= 0; b--) begin
            spiMosi = txq[i][b];
            #(HALF);
            spiSck = 1'b1;
            r[b] = spiMiso;
            #(HALF);
            spiSck = 1'b0;
         end
         rxq.push_back(r);
      end
      #(HALF);
      // released line shows the inverse of its last bit, clock stands low
      spiMosi = ~spiMosi;
      spiSsN  = 1'b1;
      #(3*HALF);
   endtask : frame
endmodule : ntac_host_model

// ===== ntac_cmd_test.sv
`timescale 1ns/100ps
`include "ntac_defines.svh"
module ntac_cmd_test;
   import ntac_pkg::*;
   logic          clock         = 1'b0;
   logic          rst           = 1'b1;
   logic          protoSelPulse = 1'b0;
   logic          acStateLoad   = 1'b0;
   logic [7:0]    acStateIn     = 8'h00;
   logic          spiSck;
   logic          spiMosi;
   logic          spiSsN;
   logic          spiMiso;
   logic          spiMisoOe;
   logic [7:0]    demodTimerWindow;
   logic [7:0]    emuState;
   logic [7:0]    regAddrPtr;
   logic          autoSyncFilterEn;
   logic          acFilterActive;
   logic          bufferAllFrames;
   ntac_acf_cfg_t acfConfig;
   int            bad_count     = 0;
   int            num_checks    = 0;
   logic [7:0]    twv [4]       = '{8'h4f, 8'h50, 8'h61, 8'h60};
   logic [7:0]    twe [4]       = '{8'h58, 8'h50, 8'h50, 8'h60};
   logic [7:0]    acl [3]       = '{8'h07, 8'h0b, 8'h0f};
   logic [7:0]    badl [3]      = '{8'h03, 8'h08, 8'h10};
   logic [7:0]    st [6]        = '{8'h00, 8'h01, 8'h04, 8'h80, 8'h81, 8'h84};

   always #20 clock = ~clock;

   ntac_cmd dut (
      .clock(clock), .rst(rst), .spiSck(spiSck), .spiMosi(spiMosi), .spiSsN(spiSsN),
      .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .protoSelPulse(protoSelPulse),
      .acStateLoad(acStateLoad), .acStateIn(acStateIn), .demodTimerWindow(demodTimerWindow),
      .autoSyncFilterEn(autoSyncFilterEn), .acFilterActive(acFilterActive), .emuState(emuState),
      .acfConfig(acfConfig), .regAddrPtr(regAddrPtr), .bufferAllFrames(bufferAllFrames)
   );

   ntac_host_model host (
      .spiSck(spiSck), .spiMosi(spiMosi), .spiSsN(spiSsN), .spiMiso(spiMiso)
   );

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected value at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   // reply is read in a later frame, so sync latency never races the slot
   task automatic xact(input logic [7:0] c [$], input logic [7:0] rep [$]);
      logic [7:0] d [$];
      host.frame(c);
      foreach (rep[i]) d.push_back(8'h00);
      host.frame(d);
      foreach (rep[i]) check(host.rxq[i], rep[i]);
   endtask : xact

   task automatic pulse(input logic isProto, input logic [7:0] val);
      @(posedge clock);
      protoSelPulse <= isProto;
      acStateLoad   <= ~isProto;
      acStateIn     <= val;
      @(posedge clock);
      protoSelPulse <= 1'b0;
      acStateLoad   <= 1'b0;
      repeat (2) @(posedge clock);
   endtask : pulse

   initial begin
      repeat (60000) @(posedge clock);
      bad_count++;
      end_of_test();
   end

   initial begin
      logic [7:0] c [$];
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      check(demodTimerWindow, `NTAC_TW_RESET);
      check({7'h00, autoSyncFilterEn}, 8'h00);
      check({7'h00, bufferAllFrames}, 8'h01);
      check({7'h00, spiMisoOe}, 8'h00);
      pulse(1'b1, 8'h00);
      xact({8'h09, 8'h04, 8'h3a, 8'h00, 8'h58, 8'h04}, {8'h00, 8'h00});
      check(demodTimerWindow, 8'h58);
      check(regAddrPtr, 8'h3a);
      // range edges, out of range kept out
      foreach (twv[i]) begin
         xact({8'h09, 8'h04, 8'h3a, 8'h00, twv[i], 8'h04}, {8'h00, 8'h00});
         check(demodTimerWindow, twe[i]);
      end
      // wrong confirmation leaves the window alone
      xact({8'h09, 8'h04, 8'h3a, 8'h00, 8'h55, 8'h00}, {8'h00, 8'h00});
      check(demodTimerWindow, 8'h60);
      xact({8'h09, 8'h03, 8'h3a, 8'h01, 8'h56}, {8'h00, 8'h00});
      check(demodTimerWindow, 8'h56);
      check(regAddrPtr, 8'h3b);
      xact({8'h09, 8'h04, 8'h0a, 8'h01, 8'h02, 8'ha1}, {8'h00, 8'h00});
      check({7'h00, autoSyncFilterEn}, 8'h01);
      check(regAddrPtr, 8'h0b);
      // other confirmed value disables, short form enables again
      xact({8'h09, 8'h04, 8'h0a, 8'h00, 8'h00, 8'ha1}, {8'h00, 8'h00});
      check({7'h00, autoSyncFilterEn}, 8'h00);
      xact({8'h09, 8'h03, 8'h0a, 8'h00, 8'h02}, {8'h00, 8'h00});
      check({7'h00, autoSyncFilterEn}, 8'h01);
      pulse(1'b1, 8'h00);
      check({7'h00, autoSyncFilterEn}, 8'h00);
      check(demodTimerWindow, 8'h52);
      // unknown first byte drops the whole frame
      xact({8'h55, 8'h09, 8'h04, 8'h3a, 8'h00, 8'h5a, 8'h04}, {8'h00, 8'h00});
      check(demodTimerWindow, 8'h52);
      foreach (acl[i]) begin
         c = {8'h0d, acl[i], 8'h44, 8'h03, 8'h20};
         for (int k = 3; k < acl[i]; k++) c.push_back(8'h80 + k[7:0]);
         xact(c, {8'h00, 8'h00});
         check({7'h00, acFilterActive}, 8'h01);
         check(acfConfig.sak, 8'h20);
         check(acfConfig.uid[95:88], 8'h83);
         check(acfConfig.atqa[15:8], 8'h44);
         check(acfConfig.atqa[7:0], 8'h03);
         check({6'h00, acfConfig.levels}, 8'(i + 1));
      end
      check({7'h00, bufferAllFrames}, 8'h00);
      foreach (badl[i]) xact({8'h0d, badl[i]}, {8'h82, 8'h00});
      // write with a length other than 3 or 4, state read with nonzero payload
      xact({8'h09, 8'h05}, {8'h82, 8'h00});
      xact({8'h0d, 8'h02, 8'h01, 8'h00}, {8'h82, 8'h00});
      check({7'h00, acFilterActive}, 8'h01);
      foreach (st[i]) begin
         xact({8'h0d, 8'h01, st[i]}, {8'h00, 8'h00});
         xact({8'h0d, 8'h02, 8'h00, 8'h00}, {8'h00, 8'h01, st[i]});
         check(emuState, st[i]);
      end
      check({7'h00, acFilterActive}, 8'h01);
      // internal machine load
      pulse(1'b0, `NTAC_ST_READY_HALT);
      check(emuState, 8'h81);
      xact({8'h0d, 8'h00}, {8'h00, 8'h01, 8'h81});
      check({7'h00, acFilterActive}, 8'h00);
      check({7'h00, bufferAllFrames}, 8'h01);
      // output enable looked at mid-frame, off the clock edge
      fork
         xact({8'h0d, 8'h02, 8'h00, 8'h00}, {8'h00, 8'h01, 8'h81});
         begin
            repeat (10) @(negedge clock);
            check({7'h00, spiMisoOe}, 8'h01);
         end
      join
      end_of_test();
   end
endmodule : ntac_cmd_test
